//--- inc/sched_pkg.sv
// constants and types for the time-slice task scheduler
// assumes a single 250 MHz clock; all counts are in cycles of that clock
package sched_pkg;

	localparam int CLK_MHZ = 250;
	localparam int TASK_COUNT = 4;
	localparam int TASK_W = 2;
	localparam int SCAN_W = 3;
	localparam int PROG_COUNT = 8;
	localparam int PROG_W = 3;
	localparam int PROFILE_COUNT = 2;
	localparam int PERIOD_W = 32;

	// update period when the user has not configured one
	localparam int UPDATE_DEFAULT_US = 1000;
	localparam int UPDATE_DEFAULT_CYCLES = UPDATE_DEFAULT_US * CLK_MHZ;

	// cost of passing over a blocked task, least and longest
	localparam int SKIP_MIN_US = 50;
	localparam int SKIP_MAX_US = 100;
	localparam int SKIP_MIN_CYCLES = SKIP_MIN_US * CLK_MHZ;
	localparam int SKIP_MAX_CYCLES = SKIP_MAX_US * CLK_MHZ;

	localparam logic [TASK_W-1:0] TASK_ZERO = 2'h0;
	localparam logic [TASK_W-1:0] TASK_STEP = 2'h1;
	localparam logic [SCAN_W-1:0] SCAN_ZERO = 3'h0;
	localparam logic [SCAN_W-1:0] SCAN_STEP = 3'h1;
	localparam logic [SCAN_W-1:0] SCAN_ALL = 3'h4;
	localparam logic [PERIOD_W-1:0] PERIOD_ZERO = 32'h0;
	localparam logic [PERIOD_W-1:0] PERIOD_STEP = 32'h1;

	// instruction that asked to block its task
	typedef enum logic [2:0] {
		BLK_INDEX = 3'h0,
		BLK_HOME = 3'h1,
		BLK_JOG_POS = 3'h2,
		BLK_JOG_NEG = 3'h3,
		BLK_DWELL_TIME = 3'h4,
		BLK_DWELL_MASTER = 3'h5,
		BLK_TIMED_WAIT = 3'h6,
		BLK_COND_WAIT = 3'h7
	} block_kind_t;

	// period sequencer states, one-hot
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_LOOP = 6'h02,
		ST_MSG = 6'h04,
		ST_SELECT = 6'h08,
		ST_SKIP = 6'h10,
		ST_RUN = 6'h20
	} seq_state_t;

endpackage

//--- inc/task_table_if.sv
// carrier between the scheduler core and its program/task table
// assumes both ends share clk
`timescale 1ns/100ps
`default_nettype none
interface task_table_if;
	logic prog_assign_we;
	logic [sched_pkg::PROG_W-1:0] prog_assign_id;
	logic [sched_pkg::TASK_W-1:0] prog_assign_task;
	logic prog_start;
	logic [sched_pkg::PROG_W-1:0] prog_start_id;
	logic task_stop;
	logic [sched_pkg::TASK_W-1:0] task_stop_id;
	logic [sched_pkg::TASK_COUNT-1:0] task_assigned;
	logic [sched_pkg::TASK_COUNT-1:0] task_live;

	modport core (
		output prog_assign_we, prog_assign_id, prog_assign_task,
		output prog_start, prog_start_id, task_stop, task_stop_id,
		input task_assigned, task_live
	);
	modport store (
		input prog_assign_we, prog_assign_id, prog_assign_task,
		input prog_start, prog_start_id, task_stop, task_stop_id,
		output task_assigned, task_live
	);
endinterface
`default_nettype wire

//--- src/task_prog_table.sv
// program-to-task map and per-task initiated flags
// assumes program start and task stop arrive as one-cycle strobes
`timescale 1ns/100ps
`default_nettype none
module task_prog_table (
	input wire logic clk,
	input wire logic srst,
	task_table_if.store tbl
);

	logic [sched_pkg::TASK_W-1:0] prog_map [sched_pkg::PROG_COUNT];
	logic [sched_pkg::TASK_COUNT-1:0] initiated;
	logic [sched_pkg::TASK_W-1:0] start_task;

	// every program sits on task zero until moved elsewhere
	always_ff @(posedge clk) begin
		if (srst) begin
			for (int p = 0; p < sched_pkg::PROG_COUNT; p++) begin
				prog_map[p] <= sched_pkg::TASK_ZERO;
			end
		end else if (tbl.prog_assign_we) begin
			prog_map[tbl.prog_assign_id] <= tbl.prog_assign_task;
		end
	end

	assign start_task = prog_map[tbl.prog_start_id];

	genvar t;
	generate
		for (t = 0; t < sched_pkg::TASK_COUNT; t++) begin : g_task
			// a task counts as assigned while any program maps to it
			always_comb begin
				tbl.task_assigned[t] = 1'b0;
				for (int p = 0; p < sched_pkg::PROG_COUNT; p++) begin
					if (prog_map[p] == t[sched_pkg::TASK_W-1:0]) begin
						tbl.task_assigned[t] = 1'b1;
					end
				end
			end

			// start beats a stop landing in the same cycle
			always_ff @(posedge clk) begin
				if (srst) begin
					initiated[t] <= 1'b0;
				end else if (tbl.prog_start && start_task == t[sched_pkg::TASK_W-1:0]) begin
					initiated[t] <= 1'b1;
				end else if (tbl.task_stop && tbl.task_stop_id == t[sched_pkg::TASK_W-1:0]) begin
					initiated[t] <= 1'b0;
				end
			end
		end
	endgenerate

	assign tbl.task_live = initiated & tbl.task_assigned;

endmodule
`default_nettype wire

//--- src/time_slice_task_scheduler.sv
// period sequencer for a motion controller: update tick, control loop,
// message service and round-robin user tasks, one per period unless a task blocks or stops mid-slice
// assumes all inputs are synchronous to clk and the loop/message
// engines answer their requests with a done level or pulse
// update_period may change at any time; a value below the count already reached ends the period at once
`timescale 1ns/100ps
`default_nettype none
module time_slice_task_scheduler #(
	parameter int UPDATE_CYCLES = sched_pkg::UPDATE_DEFAULT_CYCLES,
	parameter int SKIP_CYCLES = sched_pkg::SKIP_MIN_CYCLES
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [sched_pkg::PERIOD_W-1:0] update_period,
	input wire logic loop_update_done,
	input wire logic modbus_req_pending,
	input wire logic fault_active,
	input wire logic msg_service_done,
	input wire logic prog_assign_we,
	input wire logic [sched_pkg::PROG_W-1:0] prog_assign_id,
	input wire logic [sched_pkg::TASK_W-1:0] prog_assign_task,
	input wire logic prog_start,
	input wire logic [sched_pkg::PROG_W-1:0] prog_start_id,
	input wire logic task_stop,
	input wire logic [sched_pkg::TASK_W-1:0] task_stop_id,
	input wire logic block_req,
	input wire logic [sched_pkg::TASK_W-1:0] block_task,
	input wire sched_pkg::block_kind_t block_kind,
	input wire logic block_profile,
	input wire logic [sched_pkg::PROFILE_COUNT-1:0] profile_busy,
	input wire logic [sched_pkg::TASK_COUNT-1:0] wait_elapsed,
	input wire logic [sched_pkg::TASK_COUNT-1:0] cond_true,
	output logic update_tick,
	output logic loop_update_req,
	output logic msg_service_req,
	output logic task_run,
	output logic task_halt,
	output logic skip_active,
	output logic [sched_pkg::TASK_W-1:0] run_task,
	output logic [sched_pkg::TASK_W-1:0] current_turn,
	output logic [sched_pkg::TASK_COUNT-1:0] task_blocked,
	output logic [sched_pkg::TASK_COUNT-1:0] task_live
);

	localparam logic [sched_pkg::PERIOD_W-1:0] UPDATE_LIMIT = UPDATE_CYCLES[31:0];
	localparam logic [sched_pkg::PERIOD_W-1:0] SKIP_LIMIT = SKIP_CYCLES[31:0];

	task_table_if tbl ();

	sched_pkg::seq_state_t state;
	logic [sched_pkg::PERIOD_W-1:0] period_cnt;
	logic [sched_pkg::PERIOD_W-1:0] period_limit;
	logic [sched_pkg::PERIOD_W-1:0] skip_cnt;
	logic [sched_pkg::TASK_W-1:0] scan;
	logic [sched_pkg::SCAN_W-1:0] scanned;
	logic ran;
	logic [sched_pkg::TASK_W-1:0] next_turn;
	logic msg_pending;
	logic scan_live;
	logic scan_blocked;
	logic [sched_pkg::TASK_COUNT-1:0] blk_motion;
	logic [sched_pkg::TASK_COUNT-1:0] blk_timed;
	logic [sched_pkg::TASK_COUNT-1:0] blk_cond;
	logic [sched_pkg::TASK_COUNT-1:0] blk_prof;
	logic [sched_pkg::TASK_COUNT-1:0] blk_hit;
	logic [sched_pkg::TASK_COUNT-1:0] stop_hit;
	logic sel_take;
	logic slot_ok;

	// table wiring, the table owns program placement and start state
	assign tbl.prog_assign_we = prog_assign_we;
	assign tbl.prog_assign_id = prog_assign_id;
	assign tbl.prog_assign_task = prog_assign_task;
	assign tbl.prog_start = prog_start;
	assign tbl.prog_start_id = prog_start_id;
	assign tbl.task_stop = task_stop;
	assign tbl.task_stop_id = task_stop_id;

	task_prog_table i_task_prog_table (
		.clk(clk),
		.srst(srst),
		.tbl(tbl.store)
	);

	// zero period means not configured: fall back to the default rate
	assign period_limit = (update_period == sched_pkg::PERIOD_ZERO) ? UPDATE_LIMIT
		: update_period;

	// update-rate divider, its terminal count is the interrupt
	always_ff @(posedge clk) begin
		if (srst || update_tick) begin
			period_cnt <= sched_pkg::PERIOD_ZERO;
		end else begin
			period_cnt <= period_cnt + sched_pkg::PERIOD_STEP;
		end
	end

	// compare is >= so a period shortened mid-count ends at once instead of wrapping
	assign update_tick = (period_cnt >= period_limit - sched_pkg::PERIOD_STEP);

	// message step only when a master asked or a fault is up
	assign msg_pending = modbus_req_pending | fault_active;

	// state of the candidate under the scan
	assign scan_live = task_live[scan];
	assign scan_blocked = task_blocked[scan];

	// per-task blocking: cause and its release are tracked independently
	genvar t;
	generate
		for (t = 0; t < sched_pkg::TASK_COUNT; t++) begin : g_blk
			assign blk_hit[t] = block_req && block_task == t[sched_pkg::TASK_W-1:0];
			assign stop_hit[t] = task_stop && task_stop_id == t[sched_pkg::TASK_W-1:0];

			// motion and dwell block only behind a busy profile
			always_ff @(posedge clk) begin
				if (srst || stop_hit[t]) begin
					blk_motion[t] <= 1'b0;
					blk_prof[t] <= 1'b0;
				end else if (blk_hit[t] && block_kind != sched_pkg::BLK_TIMED_WAIT
					&& block_kind != sched_pkg::BLK_COND_WAIT) begin
					blk_motion[t] <= profile_busy[block_profile];
					blk_prof[t] <= block_profile;
				end else if (blk_motion[t] && !profile_busy[blk_prof[t]]) begin
					blk_motion[t] <= 1'b0;
				end
			end

			// timed wait holds until its elapsed strobe
			always_ff @(posedge clk) begin
				if (srst || stop_hit[t]) begin
					blk_timed[t] <= 1'b0;
				end else if (blk_hit[t] && block_kind == sched_pkg::BLK_TIMED_WAIT) begin
					blk_timed[t] <= !wait_elapsed[t];
				end else if (wait_elapsed[t]) begin
					blk_timed[t] <= 1'b0;
				end
			end

			// condition seen at any cycle releases the task, even off-turn
			always_ff @(posedge clk) begin
				if (srst || stop_hit[t]) begin
					blk_cond[t] <= 1'b0;
				end else if (blk_hit[t] && block_kind == sched_pkg::BLK_COND_WAIT) begin
					blk_cond[t] <= !cond_true[t];
				end else if (cond_true[t]) begin
					blk_cond[t] <= 1'b0;
				end
			end

			// any one cause keeps the task off the slice
			assign task_blocked[t] = blk_motion[t] | blk_timed[t] | blk_cond[t];
		end
	endgenerate

	// live means started and holding at least one program
	assign task_live = tbl.task_live;

	// period sequencer; the tick overrides every state
	always_ff @(posedge clk) begin
		if (srst) begin
			state <= sched_pkg::ST_IDLE;
		end else if (update_tick) begin
			state <= sched_pkg::ST_LOOP;
		end else begin
			case (state)
				sched_pkg::ST_LOOP: begin
					if (loop_update_done) begin
						state <= msg_pending ? sched_pkg::ST_MSG : sched_pkg::ST_SELECT;
					end
				end
				sched_pkg::ST_MSG: begin
					if (msg_service_done) begin
						state <= sched_pkg::ST_SELECT;
					end
				end
				sched_pkg::ST_SELECT: begin
					// a full lap without a runnable task idles to the tick
					if (scanned == sched_pkg::SCAN_ALL) begin
						state <= sched_pkg::ST_IDLE;
					end else if (scan_live && scan_blocked) begin
						state <= sched_pkg::ST_SKIP;
					end else if (scan_live) begin
						state <= sched_pkg::ST_RUN;
					end
				end
				sched_pkg::ST_SKIP: begin
					if (skip_cnt == sched_pkg::PERIOD_ZERO) begin
						state <= sched_pkg::ST_SELECT;
					end
				end
				sched_pkg::ST_RUN: begin
					// a task that blocks mid-slice gives the rest away
					if (task_blocked[run_task]) begin
						state <= sched_pkg::ST_SKIP;
					end else if (!task_live[run_task]) begin
						state <= sched_pkg::ST_SELECT;
					end
				end
				sched_pkg::ST_IDLE: begin
					state <= sched_pkg::ST_IDLE;
				end
				default: begin
					state <= sched_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// skip cost timer, loaded on entry so each skip costs the same
	always_ff @(posedge clk) begin
		if (srst) begin
			skip_cnt <= sched_pkg::PERIOD_ZERO;
		end else if (state != sched_pkg::ST_SKIP) begin
			skip_cnt <= SKIP_LIMIT - sched_pkg::PERIOD_STEP;
		end else if (skip_cnt != sched_pkg::PERIOD_ZERO) begin
			skip_cnt <= skip_cnt - sched_pkg::PERIOD_STEP;
		end
	end

	// next turn follows the task that actually ran; two-bit wrap returns to zero
	assign next_turn = ran ? run_task + sched_pkg::TASK_STEP : current_turn;

	// turn pointer moves only on the interrupt
	always_ff @(posedge clk) begin
		if (srst) begin
			current_turn <= sched_pkg::TASK_ZERO;
		end else if (update_tick) begin
			current_turn <= next_turn;
		end
	end

	// scan walks upward from the turn, one not-live candidate per cycle, a blocked one after its skip delay
	always_ff @(posedge clk) begin
		if (srst) begin
			scan <= sched_pkg::TASK_ZERO;
			scanned <= sched_pkg::SCAN_ZERO;
		end else if (update_tick) begin
			scan <= next_turn;
			scanned <= sched_pkg::SCAN_ZERO;
		end else if (state == sched_pkg::ST_SELECT && !scan_live
			&& scanned != sched_pkg::SCAN_ALL) begin
			scan <= scan + sched_pkg::TASK_STEP;
			scanned <= scanned + sched_pkg::SCAN_STEP;
		end else if (state == sched_pkg::ST_SKIP && skip_cnt == sched_pkg::PERIOD_ZERO) begin
			scan <= scan + sched_pkg::TASK_STEP;
			scanned <= scanned + sched_pkg::SCAN_STEP;
		end
	end

	// the candidate under the scan is taken for the slice this cycle
	assign sel_take = (state == sched_pkg::ST_SELECT) && scan_live && !scan_blocked
		&& (scanned != sched_pkg::SCAN_ALL);

	// record whether a task took the slice this period
	always_ff @(posedge clk) begin
		if (srst || update_tick) begin
			ran <= 1'b0;
		end else if (sel_take) begin
			ran <= 1'b1;
		end
	end

	// slice owner, kept after the slice ends so the turn can step past it
	always_ff @(posedge clk) begin
		if (srst) begin
			run_task <= sched_pkg::TASK_ZERO;
		end else if (sel_take) begin
			run_task <= scan;
		end
	end

	// a task that blocked or stopped gets no time, not even the one cycle
	// the sequencer needs to leave the run state
	assign slot_ok = (state == sched_pkg::ST_RUN) && task_live[run_task]
		&& !task_blocked[run_task];

	// handshake outputs; the tick cuts the task in its own cycle
	assign loop_update_req = (state == sched_pkg::ST_LOOP);
	assign msg_service_req = (state == sched_pkg::ST_MSG);
	assign task_run = slot_ok && !update_tick;
	assign task_halt = slot_ok && update_tick;
	assign skip_active = (state == sched_pkg::ST_SKIP);

endmodule
`default_nettype wire

//--- test/time_slice_task_scheduler_assertions.sv
// concurrent checks on the scheduler's top-level ports
// assumes tick spacing is judged only while update_period is 0
`timescale 1ns/100ps
`default_nettype none
module time_slice_task_scheduler_assertions #(
	parameter int UPDATE_CYCLES = 200,
	parameter int SKIP_CYCLES = 10
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [sched_pkg::PERIOD_W-1:0] update_period,
	input wire logic loop_update_done,
	input wire logic modbus_req_pending,
	input wire logic fault_active,
	input wire logic update_tick,
	input wire logic loop_update_req,
	input wire logic msg_service_req,
	input wire logic task_run,
	input wire logic task_halt,
	input wire logic skip_active,
	input wire logic [sched_pkg::TASK_W-1:0] run_task,
	input wire logic [sched_pkg::TASK_W-1:0] current_turn,
	input wire logic [sched_pkg::TASK_COUNT-1:0] task_blocked,
	input wire logic [sched_pkg::TASK_COUNT-1:0] task_live
);
	logic [31:0] tick_cnt;
	logic tick_seen;
	logic ran;
	logic [31:0] skip_cnt;

	// cycles since the last tick; the first period after reset is not judged
	always_ff @(posedge clk) begin
		if (srst || update_tick) tick_cnt <= 32'h0;
		else tick_cnt <= tick_cnt + 32'h1;
	end
	always_ff @(posedge clk) begin
		if (srst) tick_seen <= 1'b0;
		else if (update_tick) tick_seen <= 1'b1;
	end
	// a task held the slice in this period
	always_ff @(posedge clk) begin
		if (srst || update_tick) ran <= 1'b0;
		else if (task_run) ran <= 1'b1;
	end
	// length of the current blocked-skip delay
	always_ff @(posedge clk) begin
		if (srst || !skip_active) skip_cnt <= 32'h0;
		else skip_cnt <= skip_cnt + 32'h1;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	tick_period_a: assert property (
		update_tick && tick_seen && update_period == 32'h0 |-> tick_cnt == UPDATE_CYCLES - 1
	) else $error("tick spacing wrong");
	tick_pulse_a: assert property (
		update_tick |=> !update_tick
	) else $error("tick longer than one cycle");
	halt_loop_a: assert property (
		update_tick |=> loop_update_req && !task_run
	) else $error("tick did not start loop update");
	halt_pulse_a: assert property (
		task_halt |-> update_tick && !task_run
	) else $error("halt without tick");
	run_alone_a: assert property (
		task_run |-> !loop_update_req && !msg_service_req && !skip_active
	) else $error("task ran beside other work");
	msg_skip_a: assert property (
		loop_update_req && loop_update_done && !modbus_req_pending && !fault_active
		|=> !msg_service_req
	) else $error("message step not bypassed");
	msg_take_a: assert property (
		loop_update_req && loop_update_done && (modbus_req_pending || fault_active)
		&& !update_tick |=> msg_service_req
	) else $error("message step missed");
	run_ok_a: assert property (
		$rose(task_run) |-> task_live[run_task] && !task_blocked[run_task]
	) else $error("ineligible task ran");
	run_clean_a: assert property (
		task_run |-> task_live[run_task] && !task_blocked[run_task]
	) else $error("blocked or stopped task held the slice");
	skip_len_a: assert property (
		$fell(skip_active) && !$past(update_tick) |-> skip_cnt == SKIP_CYCLES
	) else $error("skip delay length wrong");
	turn_hold_a: assert property (
		!update_tick && !$past(srst) |=> $stable(current_turn)
	) else $error("turn moved between ticks");
	turn_step_a: assert property (
		update_tick && ran |=> current_turn == $past(run_task) + 2'h1
	) else $error("turn did not advance");

	cover property (skip_active ##1 !skip_active);
	cover property (task_halt);
	cover property (msg_service_req);
	cover property (update_tick && update_period != 32'h0);
endmodule
`default_nettype wire

//--- test/time_slice_task_scheduler_tb.sv
// self-checking bench for the time-slice scheduler
// assumes short period and skip counts; loop and message engines answer in one cycle
`timescale 1ns/100ps
`default_nettype none
module time_slice_task_scheduler_tb;
	localparam int UPD = 200;
	localparam int SKP = 10;
	logic clk = 1'b0, srst = 1'b1, loop_update_done = 1'b0, msg_service_done = 1'b0;
	logic [31:0] update_period = 32'h0;
	logic modbus_req_pending = 1'b0, fault_active = 1'b0, prog_assign_we = 1'b0, prog_start = 1'b0;
	logic [2:0] prog_assign_id = 3'h0, prog_start_id = 3'h0;
	logic [1:0] prog_assign_task = 2'h0, task_stop_id = 2'h0, block_task = 2'h0;
	logic task_stop = 1'b0, block_req = 1'b0, block_profile = 1'b0;
	sched_pkg::block_kind_t block_kind = sched_pkg::BLK_INDEX;
	logic [1:0] profile_busy = 2'h0;
	logic [3:0] wait_elapsed = 4'h0, cond_true = 4'h0;
	logic update_tick, loop_update_req, msg_service_req, task_run, task_halt, skip_active;
	logic [1:0] run_task, current_turn;
	logic [3:0] task_blocked, task_live;
	logic saw_msg, saw_skip;
	int n_mismatch = 0;
	int tests_run = 0;

	always #2 clk = ~clk;
	// engines finish one cycle after being asked
	always @(posedge clk) begin
		loop_update_done <= loop_update_req;
		msg_service_done <= msg_service_req;
	end

	time_slice_task_scheduler #(.UPDATE_CYCLES(UPD), .SKIP_CYCLES(SKP))
		i_time_slice_task_scheduler (
		.clk, .srst, .update_period, .loop_update_done, .modbus_req_pending, .fault_active,
		.msg_service_done, .prog_assign_we, .prog_assign_id, .prog_assign_task, .prog_start,
		.prog_start_id, .task_stop, .task_stop_id, .block_req, .block_task, .block_kind,
		.block_profile, .profile_busy, .wait_elapsed, .cond_true, .update_tick, .loop_update_req,
		.msg_service_req, .task_run, .task_halt, .skip_active, .run_task, .current_turn,
		.task_blocked, .task_live);

	task stop_test;
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	task chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// strobes, each one cycle wide and settled before return
	task assign_prog(input logic [2:0] id, input logic [1:0] t);
		@(posedge clk);
		prog_assign_we <= 1'b1;
		prog_assign_id <= id;
		prog_assign_task <= t;
		@(posedge clk);
		prog_assign_we <= 1'b0;
		cyc(1);
	endtask
	task start_prog(input logic [2:0] id);
		@(posedge clk);
		prog_start <= 1'b1;
		prog_start_id <= id;
		@(posedge clk);
		prog_start <= 1'b0;
		cyc(1);
	endtask
	task stop_task(input logic [1:0] t);
		@(posedge clk);
		task_stop <= 1'b1;
		task_stop_id <= t;
		@(posedge clk);
		task_stop <= 1'b0;
		cyc(1);
	endtask
	task blk(input logic [1:0] t, input sched_pkg::block_kind_t k, input logic p);
		@(posedge clk);
		block_req <= 1'b1;
		block_task <= t;
		block_kind <= k;
		block_profile <= p;
		@(posedge clk);
		block_req <= 1'b0;
		cyc(1);
	endtask

	// wait for the next tick, then for the slice, and judge which task got it
	task next_run(input logic [1:0] exp);
		int i;
		logic prev_run;
		// look off the edge so outputs launched by it have settled
		#1;
		saw_msg = 1'b0;
		saw_skip = 1'b0;
		prev_run = 1'b0;
		i = 0;
		while (update_tick !== 1'b1 && i < 2 * UPD) begin
			prev_run = task_run;
			cyc(1);
			i++;
		end
		chk(8'(i < 2 * UPD), 8'h1);
		chk(8'({task_run, task_halt}), 8'({1'b0, prev_run}));
		i = 0;
		while (task_run !== 1'b1 && i < 100) begin
			cyc(1);
			i++;
			if (msg_service_req === 1'b1) saw_msg = 1'b1;
			if (skip_active === 1'b1) saw_skip = 1'b1;
		end
		chk(8'(task_run), 8'h1);
		chk(8'(run_task), 8'(exp));
	endtask

	task t_default;
		start_prog(3'h0);
		chk(8'(task_live), 8'h1);
		next_run(2'h0);
		next_run(2'h0);
	endtask
	task t_rotate;
		for (int i = 1; i < 4; i++) assign_prog(3'(i), 2'(i));
		for (int i = 1; i < 4; i++) start_prog(3'(i));
		chk(8'(task_live), 8'hf);
		for (int i = 1; i < 5; i++) next_run(2'(i));
	endtask
	task t_unstarted;
		stop_task(2'h1);
		chk(8'(task_live), 8'hd);
		next_run(2'h2);
		next_run(2'h3);
		next_run(2'h0);
	endtask
	task t_msg;
		@(posedge clk) fault_active <= 1'b1;
		next_run(2'h2);
		chk(8'(saw_msg), 8'h1);
		@(posedge clk) begin
			fault_active <= 1'b0;
			modbus_req_pending <= 1'b1;
		end
		next_run(2'h3);
		chk(8'(saw_msg), 8'h1);
		@(posedge clk) modbus_req_pending <= 1'b0;
		next_run(2'h0);
		chk(8'(saw_msg), 8'h0);
	endtask
	task t_blocked;
		blk(2'h2, sched_pkg::BLK_COND_WAIT, 1'b0);
		chk(8'(task_blocked), 8'h4);
		next_run(2'h3);
		chk(8'(saw_skip), 8'h1);
		@(posedge clk) cond_true <= 4'h4;
		@(posedge clk) cond_true <= 4'h0;
		cyc(1);
		chk(8'(task_blocked), 8'h0);
		next_run(2'h0);
		next_run(2'h2);
	endtask
	task t_kinds;
		@(posedge clk) profile_busy <= 2'h2;
		blk(2'h3, sched_pkg::BLK_INDEX, 1'b0);
		chk(8'(task_blocked), 8'h0);
		for (int k = 0; k < 6; k++) begin
			blk(2'h3, sched_pkg::block_kind_t'(k), 1'b1);
			chk(8'(task_blocked), 8'h8);
			@(posedge clk) profile_busy <= 2'h0;
			cyc(1);
			chk(8'(task_blocked), 8'h0);
			@(posedge clk) profile_busy <= 2'h2;
		end
		blk(2'h3, sched_pkg::BLK_TIMED_WAIT, 1'b0);
		chk(8'(task_blocked), 8'h8);
		@(posedge clk) wait_elapsed <= 4'h8;
		@(posedge clk) wait_elapsed <= 4'h0;
		cyc(1);
		chk(8'(task_blocked), 8'h0);
	endtask
	// a configured rate of 100 cycles replaces the default
	task t_rate;
		int n;
		n = 0;
		@(posedge clk) update_period <= 32'h64;
		cyc(1);
		while (update_tick !== 1'b1 && n < 2 * UPD) begin
			cyc(1);
			n++;
		end
		n = 0;
		cyc(1);
		while (update_tick !== 1'b1 && n < 2 * UPD) begin
			cyc(1);
			n++;
		end
		chk(8'(n), 8'h63);
		@(posedge clk) update_period <= 32'h0;
	endtask

	initial begin
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		cyc(1);
		chk(8'(current_turn), 8'h0);
		chk(8'(task_live), 8'h0);
		t_default();
		t_rotate();
		t_unstarted();
		t_msg();
		t_blocked();
		t_kinds();
		t_rate();
		stop_test();
	end

	// about sixteen periods are expected; this is several times that
	initial begin
		#100000;
		n_mismatch++;
		stop_test();
	end
endmodule

bind time_slice_task_scheduler time_slice_task_scheduler_assertions #(
	.UPDATE_CYCLES(UPDATE_CYCLES), .SKIP_CYCLES(SKIP_CYCLES)
) i_time_slice_task_scheduler_assertions (
	.clk, .srst, .update_period, .loop_update_done, .modbus_req_pending, .fault_active,
	.update_tick, .loop_update_req, .msg_service_req, .task_run, .task_halt, .skip_active,
	.run_task, .current_turn, .task_blocked, .task_live);
`default_nettype wire
